// >>> asrs_pkg.sv
// Package holding constants and types for the ACPI sleep rail sequencer
package asrs_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam real POR_EXT_MS = 3.3;
	localparam real MSEL_MS = 3.0;
	localparam real DEGLITCH_US = 200.0;
	localparam real ACT_HOLD_MS = 50.0;
	localparam int unsigned POR_EXT_CYC = int'($ceil(POR_EXT_MS * CLK_HZ / 1.0e3));
	localparam int unsigned MSEL_CYC = int'($ceil(MSEL_MS * CLK_HZ / 1.0e3));
	localparam int unsigned DEGLITCH_CYC = int'($ceil(DEGLITCH_US * CLK_HZ / 1.0e6));
	localparam int unsigned ACT_HOLD_CYC = int'($ceil(ACT_HOLD_MS * CLK_HZ / 1.0e3));
	localparam int CNT_W = 24;
	localparam logic [1:0] SYNC_RST = 2'h0;

	typedef enum logic [2:0] {
		ST_ACTIVE = 3'b001,
		ST_S3 = 3'b010,
		ST_S45 = 3'b100
	} asrs_state_t;

	typedef struct packed {
		logic activeSwitchDrive;
		logic dual33SleepDrive;
		logic dual5StandbyDrive;
		logic memActiveDrive;
		logic memActiveRegulate;
		logic memSleepPass;
	} asrs_drive_t;

	typedef struct packed {
		logic memUv;
		logic dual33Uv;
		logic dual5Uv;
		logic overTemp;
	} asrs_mon_t;

	localparam asrs_drive_t DRIVE_OFF = '0;
endpackage : asrs_pkg

// >>> asrs_sequencer.sv
// Digital control core of the triple rail ACPI sleep sequencer
`timescale 1ns/1ps
module asrs_sequencer #(
	parameter int unsigned POR_EXT_CYCLES = asrs_pkg::POR_EXT_CYC,
	parameter int unsigned MSEL_CYCLES = asrs_pkg::MSEL_CYC,
	parameter int unsigned ACT_HOLD_CYCLES = asrs_pkg::ACT_HOLD_CYC
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic standbyAboveThr,
	input wire logic supply12Good,
	input wire logic sleep3_req_n,
	input wire logic sleep5_req_n,
	input wire logic dual33_sleep_strap,
	input wire logic dual5_sleep_strap,
	input wire logic softStartLow,
	input wire asrs_pkg::asrs_mon_t monIn,
	input wire logic fault_memsel_pin_in,
	output logic fault_memsel_pin_out,
	output logic fault_memsel_pin_oe,
	output asrs_pkg::asrs_drive_t driveOut,
	output logic mem_level_select,
	output asrs_pkg::asrs_state_t stateOut,
	output logic porActive
);
	import asrs_pkg::*;

	// Two-flop synchronizers; only stage two is read by logic
	logic [10:0] syncA_reg;
	logic [10:0] syncB_reg;
	wire logic [10:0] rawIn = {standbyAboveThr, supply12Good, sleep3_req_n, sleep5_req_n,
		dual33_sleep_strap, dual5_sleep_strap, softStartLow, monIn};
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			syncA_reg <= '0;
			syncB_reg <= '0;
		end else begin
			syncA_reg <= rawIn;
			syncB_reg <= syncA_reg;
		end
	end
	logic selPinA_reg;
	logic selPinB_reg;
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			selPinA_reg <= 1'b0;
			selPinB_reg <= 1'b0;
		end else begin
			selPinA_reg <= fault_memsel_pin_in;
			selPinB_reg <= selPinA_reg;
		end
	end
	wire logic sbOk = syncB_reg[10];
	wire logic v12Ok = syncB_reg[9];
	wire logic s3n = syncB_reg[8];
	wire logic s5n = syncB_reg[7];
	wire logic strap33 = syncB_reg[6];
	wire logic strap5 = syncB_reg[5];
	wire logic shutdown = syncB_reg[4];
	wire asrs_mon_t mon = asrs_mon_t'(syncB_reg[3:0]);

	// Internal power-on reset extension
	logic [CNT_W-1:0] porCnt_reg;
	logic porHold_reg;
	always_ff @(posedge ref_clk) begin
		if (!resetn || !sbOk) begin
			porCnt_reg <= '0;
			porHold_reg <= 1'b1;
		end else if (porHold_reg) begin
			if (porCnt_reg == CNT_W'(POR_EXT_CYCLES - 1)) begin
				porHold_reg <= 1'b0;
			end
			porCnt_reg <= porCnt_reg + 1'b1;
		end
	end
	assign porActive = porHold_reg;

	// Release only at the terminal count; a new hold takes every drive down
	AST_POR_COUNT: assert property (@(posedge ref_clk) disable iff (!resetn)
		$fell(porHold_reg) |-> ($past(porCnt_reg) == CNT_W'(POR_EXT_CYCLES - 1)))
		else $error("internal reset released off its count");
	AST_POR_DRIVES_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
		porHold_reg |=> ##1 (driveOut == DRIVE_OFF))
		else $error("drive active while internal reset held");

	// Memory level select sampled once after release
	logic [CNT_W-1:0] mselCnt_reg;
	logic mselDone_reg;
	logic memSel_reg;
	always_ff @(posedge ref_clk) begin
		if (!resetn || porHold_reg) begin
			mselCnt_reg <= '0;
			mselDone_reg <= 1'b0;
			memSel_reg <= 1'b0;
		end else if (!mselDone_reg) begin
			mselCnt_reg <= mselCnt_reg + 1'b1;
			if (mselCnt_reg == CNT_W'(MSEL_CYCLES - 1)) begin
				mselDone_reg <= 1'b1;
				memSel_reg <= selPinB_reg;
			end
		end
	end
	assign mem_level_select = memSel_reg;

	AST_MSEL_COUNT: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(mselDone_reg) |-> ($past(mselCnt_reg) == CNT_W'(MSEL_CYCLES - 1)))
		else $error("memory level latched off its count");

	// Request deglitch: a change in the request pair must stand for the whole window
	logic [1:0] reqPrev_reg;
	logic [CNT_W-1:0] dgCnt_reg;
	logic reqValid_reg;
	always_ff @(posedge ref_clk) begin
		if (!resetn || porHold_reg) begin
			reqPrev_reg <= 2'h3;
			dgCnt_reg <= '0;
			reqValid_reg <= 1'b0;
		end else begin
			reqPrev_reg <= {s5n, s3n};
			reqValid_reg <= 1'b0;
			if ({s5n, s3n} != reqPrev_reg) begin
				dgCnt_reg <= '0;
			end else if (dgCnt_reg != CNT_W'(DEGLITCH_CYC)) begin
				dgCnt_reg <= dgCnt_reg + 1'b1;
			end else begin
				reqValid_reg <= 1'b1;
			end
		end
	end

	// Decoded request: the pair that passed the window, not the live pins, so a
	// change in the cycle right after validation cannot slip through
	logic reqLegal;
	asrs_state_t reqState;
	always_comb begin
		reqLegal = 1'b1;
		reqState = ST_ACTIVE;
		unique case (reqPrev_reg)
			2'h3: reqState = ST_ACTIVE;
			2'h2: reqState = ST_S3;
			2'h0: reqState = ST_S45;
			default: reqLegal = 1'b0;
		endcase
	end

	// Operating state; first state after release follows the request pair
	asrs_state_t state_reg;
	logic started_reg;
	logic shutPrev_reg;
	always_ff @(posedge ref_clk) begin
		if (!resetn || porHold_reg) begin
			state_reg <= ST_ACTIVE;
			started_reg <= 1'b0;
		end else if (!started_reg) begin
			if (reqValid_reg && reqLegal) begin
				state_reg <= reqState;
				started_reg <= 1'b1;
			end
		end else if (reqValid_reg && reqLegal && !shutdown) begin
			unique case (state_reg)
				ST_ACTIVE: state_reg <= reqState;
				ST_S3: if (reqState == ST_ACTIVE) state_reg <= ST_ACTIVE;
				ST_S45: if (reqState == ST_ACTIVE) state_reg <= ST_ACTIVE;
			endcase
		end
	end
	assign stateOut = state_reg;
	wire logic sleeping = started_reg && (state_reg != ST_ACTIVE);

	// No state move without a validated request, and none while shut down once the first state is taken
	AST_DEGLITCH: assert property (@(posedge ref_clk) disable iff (!resetn)
		(!reqValid_reg && !porHold_reg) |=> $stable(state_reg))
		else $error("state moved without a validated request");
	AST_SHUT_BLOCK: assert property (@(posedge ref_clk) disable iff (!resetn)
		(started_reg && shutdown && !porHold_reg) |=> $stable(state_reg))
		else $error("state moved during shutdown");

	// Strap latches
	logic strap33_reg;
	logic strap5_reg;
	logic wasSleep_reg;
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			strap33_reg <= 1'b0;
			strap5_reg <= 1'b0;
			wasSleep_reg <= 1'b0;
			shutPrev_reg <= 1'b0;
		end else begin
			wasSleep_reg <= sleeping;
			shutPrev_reg <= shutdown;
			// Tracks the straps up to the edge that enters sleep, so the first sleep
			// drive already sees them; changes during sleep are taken only as shutdown ends
			if (porHold_reg || !sleeping || (shutPrev_reg && !shutdown)) begin
				strap33_reg <= strap33;
				strap5_reg <= strap5;
			end
		end
	end

	// Hold-off after 12V good before driving in the active state
	logic [CNT_W-1:0] holdCnt_reg;
	logic actReady_reg;
	always_ff @(posedge ref_clk) begin
		if (!resetn || porHold_reg || !v12Ok) begin
			holdCnt_reg <= '0;
			actReady_reg <= 1'b0;
		end else if (!actReady_reg) begin
			holdCnt_reg <= holdCnt_reg + 1'b1;
			if (holdCnt_reg == CNT_W'(ACT_HOLD_CYCLES - 1)) begin
				actReady_reg <= 1'b1;
			end
		end
	end

	AST_HOLD_COUNT: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(actReady_reg) |-> ($past(holdCnt_reg) == CNT_W'(ACT_HOLD_CYCLES - 1)))
		else $error("active hold-off ended off its count");

	// Rail drive decode
	asrs_drive_t drvNext;
	logic on33;
	logic on5;
	always_comb begin
		drvNext = DRIVE_OFF;
		on33 = (state_reg != ST_S45) || !strap33_reg;
		on5 = (state_reg == ST_ACTIVE) || strap5_reg;
		if (!started_reg || shutdown || !mselDone_reg) begin
			drvNext = DRIVE_OFF;
		end else if (state_reg == ST_ACTIVE) begin
			if (actReady_reg) begin
				drvNext.activeSwitchDrive = 1'b1;
				drvNext.memActiveDrive = 1'b1;
				drvNext.memActiveRegulate = !memSel_reg;
			end
		end else begin
			drvNext.dual33SleepDrive = on33;
			drvNext.dual5StandbyDrive = on5;
			drvNext.memSleepPass = (state_reg == ST_S3);
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			driveOut <= DRIVE_OFF;
		end else begin
			driveOut <= drvNext;
		end
	end

	// Drives follow the state and the latched straps one cycle later
	AST_DUAL33_S3: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sleeping && state_reg == ST_S3 && !shutdown && mselDone_reg)
		|=> driveOut.dual33SleepDrive)
		else $error("3.3V dual drive off in S3");

	AST_DUAL33_S45: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sleeping && state_reg == ST_S45 && !shutdown && mselDone_reg)
		|=> (driveOut.dual33SleepDrive == !$past(strap33_reg)))
		else $error("3.3V dual drive disagrees with strap in S4/S5");

	AST_DUAL5_SLEEP: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sleeping && !shutdown && mselDone_reg)
		|=> (driveOut.dual5StandbyDrive == $past(strap5_reg)))
		else $error("5V standby drive disagrees with strap in sleep");

	AST_MEM_S3: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sleeping && state_reg == ST_S3 && !shutdown && mselDone_reg)
		|=> driveOut.memSleepPass)
		else $error("memory pass element off in S3");

	AST_ACTIVE_ON: assert property (@(posedge ref_clk) disable iff (!resetn)
		(started_reg && state_reg == ST_ACTIVE && actReady_reg && !shutdown && mselDone_reg)
		|=> (driveOut.activeSwitchDrive && driveOut.memActiveDrive))
		else $error("active drives off in active state");

	AST_MEM_MODE: assert property (@(posedge ref_clk) disable iff (!resetn)
		(started_reg && state_reg == ST_ACTIVE && actReady_reg && !shutdown && mselDone_reg)
		|=> (driveOut.memActiveRegulate == !$past(memSel_reg)))
		else $error("memory drive mode disagrees with level");

	AST_SLEEP_NO_ACTIVE: assert property (@(posedge ref_clk) disable iff (!resetn)
		sleeping |=> !driveOut.activeSwitchDrive)
		else $error("active switch driven in sleep");

	// Fault reporting only; no drive depends on it
	logic faultNext;
	always_comb begin
		faultNext = 1'b0;
		if (!shutdown && mselDone_reg && started_reg) begin
			faultNext = mon.overTemp;
			if (on33 && mon.dual33Uv) faultNext = 1'b1;
			if (on5 && mon.dual5Uv) faultNext = 1'b1;
			if (state_reg != ST_S45 && mon.memUv) faultNext = 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			fault_memsel_pin_out <= 1'b0;
			fault_memsel_pin_oe <= 1'b0;
		end else begin
			fault_memsel_pin_out <= faultNext;
			fault_memsel_pin_oe <= mselDone_reg;
		end
	end

	// Under-voltage on any enabled rail raises the shared pin
	AST_FAULT_MEM_UV: assert property (@(posedge ref_clk) disable iff (!resetn)
		(mon.memUv && state_reg != ST_S45 && !shutdown && mselDone_reg && started_reg)
		|=> fault_memsel_pin_out)
		else $error("memory rail under-voltage not reported");
	AST_FAULT_DUAL33_UV: assert property (@(posedge ref_clk) disable iff (!resetn)
		(mon.dual33Uv && on33 && !shutdown && mselDone_reg && started_reg)
		|=> fault_memsel_pin_out)
		else $error("3.3V dual under-voltage not reported");
	AST_FAULT_DUAL5_UV: assert property (@(posedge ref_clk) disable iff (!resetn)
		(mon.dual5Uv && on5 && !shutdown && mselDone_reg && started_reg)
		|=> fault_memsel_pin_out)
		else $error("5V dual under-voltage not reported");
	AST_NO_FAULT_EARLY: assert property (@(posedge ref_clk) disable iff (!resetn)
		!mselDone_reg |=> !fault_memsel_pin_out)
		else $error("fault raised before level select latched");

	AST_SHUTDOWN_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
		shutdown |=> (driveOut == DRIVE_OFF && !fault_memsel_pin_out))
		else $error("drives or fault active in shutdown");
	AST_NO_S3_TO_S45: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_S3) |=> (state_reg != ST_S45))
		else $error("direct S3 to S4/S5 move");
	AST_NO_S45_TO_S3: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_S45) |=> (state_reg != ST_S3))
		else $error("direct S4/S5 to S3 move");
	AST_INVALID_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
		(started_reg && !porHold_reg && reqPrev_reg == 2'h1) |=> $stable(state_reg))
		else $error("state changed on invalid request");
	AST_MEM_OFF_S45: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_reg == ST_S45) |=> (!driveOut.memSleepPass && !driveOut.memActiveDrive))
		else $error("memory rail on in S4/S5");
	AST_ACTIVE_SWITCH: assert property (@(posedge ref_clk) disable iff (!resetn)
		driveOut.activeSwitchDrive
		|-> (!driveOut.dual33SleepDrive && !driveOut.dual5StandbyDrive))
		else $error("active switch with sleep drives");
	AST_HOLDOFF: assert property (@(posedge ref_clk) disable iff (!resetn)
		!v12Ok |=> ##1 !driveOut.activeSwitchDrive)
		else $error("active drive without 12V hold-off");
	AST_STRAP_STEADY: assert property (@(posedge ref_clk) disable iff (!resetn)
		(sleeping && wasSleep_reg && !porHold_reg && !shutdown && !shutPrev_reg)
		|=> $stable(strap33_reg) && $stable(strap5_reg))
		else $error("strap latch changed during sleep");
	AST_MSEL_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
		(mselDone_reg && !porHold_reg) |=> $stable(memSel_reg))
		else $error("memory level changed after latch");
	AST_FAULT_OT: assert property (@(posedge ref_clk) disable iff (!resetn)
		(mon.overTemp && !shutdown && mselDone_reg && started_reg) |=> fault_memsel_pin_out)
		else $error("over-temperature not reported");
endmodule : asrs_sequencer

// >>> asrs_chipset_model.sv
// Chipset sleep-request and strap source with the select resistor on the shared pin
`timescale 1ns/1ps
module asrs_chipset_model
	import asrs_pkg::*;
#(
	parameter int SKEW_CYC = 100
) (
	input wire logic ref_clk,
	input wire asrs_pkg::asrs_state_t wantState,
	input wire logic wantInvalid,
	input wire logic [1:0] strapWish,
	input wire logic shutdown,
	input wire logic memSelLevel,
	input wire logic pinOut,
	input wire logic pinOe,
	output logic sleep3ReqN,
	output logic sleep5ReqN,
	output logic [1:0] strapOut,
	output logic pinIn
);
	int skewCnt = 0;
	// The select resistor sets the level whenever the sequencer is not driving
	assign pinIn = pinOe ? pinOut : memSelLevel;
	initial begin
		sleep3ReqN = 1'b1;
		sleep5ReqN = 1'b1;
		strapOut = 2'h0;
	end
	always @(posedge ref_clk) begin
		skewCnt <= (wantState == ST_S45) ? skewCnt + 1 : 0;
		if (wantInvalid) begin
			sleep3ReqN <= 1'b1;
			sleep5ReqN <= 1'b0;
		end else begin
			sleep3ReqN <= (wantState == ST_ACTIVE);
			// Soft-off request drops the S3 line first, the way a chipset skews them
			if (wantState != ST_S45 || skewCnt >= SKEW_CYC) begin
				sleep5ReqN <= (wantState != ST_S45);
			end
		end
		if ((sleep3ReqN && sleep5ReqN) || shutdown) begin
			strapOut <= strapWish;
		end
	end
endmodule : asrs_chipset_model

// >>> test_asrs_sequencer.sv
// Self-checking bench for the ACPI sleep rail sequencer
`timescale 1ns/1ps
module test_asrs_sequencer;
	import asrs_pkg::*;
	// Every state move costs a full deglitch window, which sets the run length
	localparam int SETTLE = DEGLITCH_CYC + 150;
	localparam int LIMIT = 104000;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic standbyAboveThr = 1'b0;
	logic supply12Good = 1'b0;
	logic softStartLow = 1'b1;
	asrs_mon_t monIn = '0;
	asrs_state_t wantState = ST_S3;
	logic wantInvalid = 1'b0;
	logic [1:0] strapWish = 2'h0;
	logic [1:0] oldStraps;
	logic memSel = 1'b0;
	logic memLatched;
	logic sleep3ReqN, sleep5ReqN, pinIn, pinOut, pinOe, memLevel, porActive;
	logic [1:0] straps;
	asrs_drive_t driveOut;
	asrs_state_t stateOut;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;

	always #5 ref_clk = ~ref_clk;

	asrs_sequencer #(.POR_EXT_CYCLES(20), .MSEL_CYCLES(10), .ACT_HOLD_CYCLES(30)) dut (
		.ref_clk(ref_clk), .resetn(resetn), .standbyAboveThr(standbyAboveThr),
		.supply12Good(supply12Good), .sleep3_req_n(sleep3ReqN), .sleep5_req_n(sleep5ReqN),
		.dual33_sleep_strap(straps[1]), .dual5_sleep_strap(straps[0]),
		.softStartLow(softStartLow), .monIn(monIn), .fault_memsel_pin_in(pinIn),
		.fault_memsel_pin_out(pinOut), .fault_memsel_pin_oe(pinOe), .driveOut(driveOut),
		.mem_level_select(memLevel), .stateOut(stateOut), .porActive(porActive)
	);

	asrs_chipset_model model (
		.ref_clk(ref_clk), .wantState(wantState), .wantInvalid(wantInvalid),
		.strapWish(strapWish), .shutdown(softStartLow), .memSelLevel(memSel),
		.pinOut(pinOut), .pinOe(pinOe), .sleep3ReqN(sleep3ReqN), .sleep5ReqN(sleep5ReqN),
		.strapOut(straps), .pinIn(pinIn)
	);

	task automatic stop_test();
		if (n_fail == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step

	function automatic asrs_drive_t expDrive(input asrs_state_t st, input logic [1:0] sp,
		input logic ms);
		asrs_drive_t d;
		d = DRIVE_OFF;
		d.activeSwitchDrive = (st == ST_ACTIVE);
		d.memActiveDrive = (st == ST_ACTIVE);
		// Low select level means the 2.5V setting, which needs the regulating mode
		d.memActiveRegulate = (st == ST_ACTIVE) && !ms;
		d.dual33SleepDrive = (st == ST_S3) || (st == ST_S45 && !sp[1]);
		d.dual5StandbyDrive = (st != ST_ACTIVE) && sp[0];
		d.memSleepPass = (st == ST_S3);
		return d;
	endfunction : expDrive

	task automatic checkAll(input asrs_state_t st, input logic [1:0] sp);
		check("state", 8'(stateOut), 8'(st));
		check("drives", 8'(driveOut), 8'(expDrive(st, sp, memLatched)));
	endtask : checkAll

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		void'($urandom(32'ha350924f));
		memSel = 1'($urandom());
		memLatched = memSel;
		strapWish = 2'($urandom());
		// Straps are loaded while held in shutdown, then the part wakes straight into S3
		step(5);
		resetn = 1'b1;
		softStartLow = 1'b0;
		standbyAboveThr = 1'b1;
		supply12Good = 1'b1;
		step(10);
		check("por_held", 8'(porActive), 8'h1);
		step(30);
		check("por_released", 8'(porActive), 8'h0);
		step(SETTLE - 40);
		check("select_oe", 8'(pinOe), 8'h1);
		check("mem_level", 8'(memLevel), 8'(memSel));
		checkAll(ST_S3, straps);
		memSel = ~memSel;
		wantInvalid = 1'b1;
		// Held past the deglitch window so the invalid pair is really validated
		step(SETTLE);
		check("invalid_hold", 8'(stateOut), 8'(ST_S3));
		checkAll(ST_S3, straps);
		wantInvalid = 1'b0;
		wantState = ST_S45;
		step(SETTLE);
		checkAll(ST_S3, straps);
		oldStraps = straps;
		strapWish = ~oldStraps;
		wantState = ST_ACTIVE;
		step(1000);
		check("latched_straps", 8'(driveOut), 8'(expDrive(ST_S3, oldStraps, memLatched)));
		step(SETTLE - 1000);
		checkAll(ST_ACTIVE, straps);
		wantState = ST_S3;
		step(50);
		wantState = ST_ACTIVE;
		step(200);
		check("glitch", 8'(stateOut), 8'(ST_ACTIVE));
		for (int i = 0; i < 4; i++) begin
			monIn = asrs_mon_t'(4'h1 << i);
			step(6);
			check("fault_high", 8'(pinOut), 8'h1);
			check("fault_no_trip", 8'(driveOut), 8'(expDrive(ST_ACTIVE, straps, memLatched)));
			monIn = '0;
			step(6);
			check("fault_low", 8'(pinOut), 8'h0);
		end
		wantState = ST_S45;
		step(SETTLE);
		checkAll(ST_S45, straps);
		check("mem_level_held", 8'(memLevel), 8'(memLatched));
		monIn = asrs_mon_t'(4'h1);
		softStartLow = 1'b1;
		step(6);
		check("shutdown_drives", 8'(driveOut), 8'(DRIVE_OFF));
		check("shutdown_fault", 8'(pinOut), 8'h0);
		stop_test();
	end
endmodule : test_asrs_sequencer
